// File: src/itc_pacer.sv
// interrupt pacing engine: enforces the minimum gap between host interrupts
`timescale 1ns/1ps
`include "itc_params.svh"
module itc_pacer
    import itc_pkg::*;
#(
    parameter int UNIT_CYCLES = `ITC_UNIT_CYCLES
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] interval,
    input  wire logic        pending,
    output logic             irq,
    output logic             fired
);
    localparam int UW = (UNIT_CYCLES > 1) ? $clog2(UNIT_CYCLES) : 1;

    itc_pace_e     state;
    logic [UW-1:0] sub_cnt;
    logic [15:0]   unit_cnt;
    logic          gap_done;

    assign gap_done = (unit_cnt >= interval);

    // pacing state: idle, counting the gap, or gap elapsed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= ITC_IDLE;
        else
        begin
            case (state)
                ITC_IDLE:
                    if (pending && interval != 16'h0000)
                        state <= ITC_GAP;
                ITC_GAP:
                    if (interval == 16'h0000 || gap_done)
                        state <= ITC_READY;
                ITC_READY:
                    if (!pending)
                        state <= ITC_READY;
                    else if (interval != 16'h0000)
                        state <= ITC_GAP;
                default:
                    state <= ITC_IDLE;
            endcase
        end
    end

    // gap counter in 256 ns units
    // restart at each interrupt
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sub_cnt  <= '0;
            unit_cnt <= 16'h0000;
        end
        else if (fired_next())
        begin
            sub_cnt  <= '0;
            unit_cnt <= 16'h0000;
        end
        else if (state == ITC_GAP && !gap_done)
        begin
            if (sub_cnt == UW'(UNIT_CYCLES - 1))
            begin
                sub_cnt  <= '0;
                unit_cnt <= unit_cnt + 16'h0001;
            end
            else
                sub_cnt <= sub_cnt + UW'(1);
        end
    end

    function automatic logic fired_next();
        // no interrupt before the gap elapses
        fired_next = pending && !irq &&
                     (interval == 16'h0000 || state == ITC_IDLE || state == ITC_READY);
    endfunction

    // interrupt line and one-cycle assertion pulse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq   <= 1'b0;
            fired <= 1'b0;
        end
        else
        begin
            irq   <= pending && (irq || fired_next());
            fired <= fired_next();
        end
    end
endmodule

// File: src/itc_params.svh
// register offsets, field positions, reset values and timing counts of the interrupt pacing block
`ifndef ITC_PARAMS_SVH
`define ITC_PARAMS_SVH
`define ITC_OFF_PACING      12'h0C4
`define ITC_OFF_CAUSE_FORCE 12'h0C8
`define ITC_OFF_CAUSE_READ  12'h0C0
`define ITC_OFF_MASK_SET    12'h0D0
`define ITC_OFF_MASK_CLEAR  12'h0D8
`define ITC_OFF_CAUSE_CLEAR 12'h0DC
`define ITC_OFF_IRQ_STATUS  12'h0E0
`define ITC_OFF_IRQ_MASK    12'h0E4
`define ITC_INTERVAL_MSB    15
`define ITC_INTERVAL_LSB    0
`define ITC_INTERVAL_RESET  16'h0000
`define ITC_CAUSE_W         17
`define ITC_CAUSE_VALID     17'h1F6DF
`define ITC_CAUSE_RESET     17'h00000
`define ITC_MASK_RESET      17'h00000
`define ITC_EV_W            2
`define ITC_EV_RESET        2'h0
`define ITC_UNIT_NS         256
`define ITC_CLK_PERIOD_NS   40
`define ITC_UNIT_CYCLES     ((`ITC_UNIT_NS + `ITC_CLK_PERIOD_NS - 1) / `ITC_CLK_PERIOD_NS)
`endif

// File: src/itc_pkg.sv
// types shared by the interrupt pacing block
package itc_pkg;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } itc_apb_req_s;

    typedef enum logic [2:0] {
        ITC_IDLE  = 3'b001,
        ITC_GAP   = 3'b010,
        ITC_READY = 3'b100
    } itc_pace_e;
endpackage

// File: src/itc_top.sv
// interrupt cause, mask and pacing block with apb register access
//
// Overview of operation
// - a 16-bit interval in bits 15:0 of the pacing register counts 256 ns units of gap.
// - an interval of zero turns pacing off and interrupts pass without gap.
// - with a nonzero interval, two host interrupts are never closer than the interval.
// - the interval reads zero after reset so pacing starts disabled.
// - each one written to the cause-force register sets that cause bit, except reserved bits 5, 8 and, on the narrow variant, 11.
// - zeros written to the cause-force register leave causes unchanged.
// - a forced cause whose mask bit is set raises the host interrupt.
// - force bits 0, 1, 2 are tx descriptor written back, tx queue empty, link change.
// - force bit 3 is rx sequence error and bit 4 rx descriptor minimum threshold.
// - force bit 6 is rx fifo overrun and bit 7 rx timer expiry.
// - force bits 9, 10, 12 are management done, config ordered set, transceiver.
// - force bits 14:13 are general purpose pin causes, plus bit 11 on the wider variant.
// - force bit 15 is tx descriptor low threshold and bit 16 small rx packet.
// - a cause reaches the host only when its mask bit is one.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "itc_params.svh"
module itc_top
    import itc_pkg::*;
#(
    parameter logic        WIDE_GPI    = 1'b0,
    parameter int          UNIT_CYCLES = `ITC_UNIT_CYCLES
)
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [`ITC_CAUSE_W-1:0] hw_cause,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    output logic                         host_irq,
    output logic                         irq
);
    // cause bit positions
    localparam int TX_DESC_WRITTEN_BACK        = 0;
    localparam int TX_QUEUE_EMPTY              = 1;
    localparam int LINK_STATUS_CHANGE          = 2;
    localparam int RX_SEQUENCE_ERROR           = 3;
    localparam int RX_DESC_MIN_THRESHOLD       = 4;
    localparam int RX_FIFO_OVERRUN             = 6;
    localparam int RX_TIMER_EXPIRED            = 7;
    localparam int MGMT_ACCESS_COMPLETE        = 9;
    localparam int CONFIG_ORDERED_SET_RECEIVED = 10;
    localparam int TRANSCEIVER_INTERRUPT       = 12;
    localparam int TX_DESC_LOW_THRESHOLD       = 15;
    localparam int SMALL_RX_PACKET_DETECTED    = 16;

    itc_apb_req_s              req;
    logic                      wr_acc;
    logic                      rd_acc;
    logic                      known;
    logic [15:0]               interval;
    logic [`ITC_CAUSE_W-1:0]   interrupt_cause_read;
    logic [`ITC_CAUSE_W-1:0]   interrupt_enable_set;
    logic [`ITC_CAUSE_W-1:0]   valid_bits;
    logic [`ITC_CAUSE_W-1:0]   force_bits;
    logic [`ITC_CAUSE_W-1:0]   next_cause;
    logic [`ITC_CAUSE_W-1:0]   next_enable;
    logic [`ITC_EV_W-1:0]      ev_status;
    logic [`ITC_EV_W-1:0]      ev_mask;
    logic [`ITC_EV_W-1:0]      next_ev;
    logic [31:0]               next_rdata;
    logic                      pending;
    logic                      pace_irq;
    logic                      fired;
    logic                      cause_rd_clear;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

    // one-wait access: answer in the cycle after the first access cycle
    assign wr_acc = req.psel && req.penable && req.pwrite && pready;
    assign rd_acc = req.psel && req.penable && !req.pwrite && pready;

    // valid cause bits, general purpose field widened on the variant
    // gpi field width
    assign valid_bits = WIDE_GPI ? (`ITC_CAUSE_VALID | 17'h00800) : `ITC_CAUSE_VALID;

    // address decode
    always_comb
    begin
        known = 1'b1;
        case (req.paddr)
            `ITC_OFF_PACING, `ITC_OFF_CAUSE_FORCE, `ITC_OFF_CAUSE_READ, `ITC_OFF_MASK_SET,
            `ITC_OFF_MASK_CLEAR, `ITC_OFF_CAUSE_CLEAR, `ITC_OFF_IRQ_STATUS, `ITC_OFF_IRQ_MASK:
                known = 1'b1;
            default:
                known = 1'b0;
        endcase
    end

    // pready pulses one cycle after the access phase begins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= req.psel && req.penable && !pready;
    end

    // error answer for unmapped addresses
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pslverr <= 1'b0;
        else
            pslverr <= req.psel && req.penable && !pready && !known;
    end

    // pacing interval register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            interval <= `ITC_INTERVAL_RESET;
        else if (wr_acc && req.paddr == `ITC_OFF_PACING)
            interval <= req.pwdata[`ITC_INTERVAL_MSB:`ITC_INTERVAL_LSB];
    end

    // forced cause bits from a cause-force write
    always_comb
    begin
        force_bits = '0;
        if (wr_acc && req.paddr == `ITC_OFF_CAUSE_FORCE)
            force_bits = req.pwdata[`ITC_CAUSE_W-1:0] & valid_bits;
    end

    // reading the cause register clears it
    assign cause_rd_clear = rd_acc && req.paddr == `ITC_OFF_CAUSE_READ;

    // cause register update, set wins over clear
    always_comb
    begin
        next_cause = interrupt_cause_read;
        if (cause_rd_clear)
            next_cause = '0;
        if (wr_acc && req.paddr == `ITC_OFF_CAUSE_CLEAR)
            next_cause = next_cause & ~req.pwdata[`ITC_CAUSE_W-1:0];
        next_cause = next_cause | force_bits | (hw_cause & valid_bits);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            interrupt_cause_read <= `ITC_CAUSE_RESET;
        else
            interrupt_cause_read <= next_cause;
    end

    // mask set and clear
    always_comb
    begin
        next_enable = interrupt_enable_set;
        if (wr_acc && req.paddr == `ITC_OFF_MASK_SET)
            next_enable = next_enable | (req.pwdata[`ITC_CAUSE_W-1:0] & valid_bits);
        if (wr_acc && req.paddr == `ITC_OFF_MASK_CLEAR)
            next_enable = next_enable & ~req.pwdata[`ITC_CAUSE_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            interrupt_enable_set <= `ITC_MASK_RESET;
        else
            interrupt_enable_set <= next_enable;
    end

    assign pending = |(interrupt_cause_read & interrupt_enable_set);

    // pacing engine
    itc_pacer #(
        .UNIT_CYCLES (UNIT_CYCLES)
    ) u_pacer (
        .pclk     (pclk),
        .presetn  (presetn),
        .interval (interval),
        .pending  (pending),
        .irq      (pace_irq),
        .fired    (fired)
    );

    // host interrupt line registered
    // paced assertion
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            host_irq <= 1'b0;
        else
            host_irq <= pace_irq;
    end

    // block events: bit0 interrupt asserted, bit1 cause forced; set wins over w1c
    always_comb
    begin
        next_ev = ev_status;
        if (wr_acc && req.paddr == `ITC_OFF_IRQ_STATUS)
            next_ev = next_ev & ~req.pwdata[`ITC_EV_W-1:0];
        next_ev = next_ev | {(|force_bits), fired};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ev_status <= `ITC_EV_RESET;
        else
            ev_status <= next_ev;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ev_mask <= `ITC_EV_RESET;
        else if (wr_acc && req.paddr == `ITC_OFF_IRQ_MASK)
            ev_mask <= req.pwdata[`ITC_EV_W-1:0];
    end

    // level event interrupt
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(next_ev & ev_mask);
    end

    // read data mux, write-only registers read zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (req.paddr)
            `ITC_OFF_PACING:     next_rdata = {16'h0000, interval};
            `ITC_OFF_CAUSE_READ: next_rdata = {15'h0000, interrupt_cause_read};
            `ITC_OFF_MASK_SET:   next_rdata = {15'h0000, interrupt_enable_set};
            `ITC_OFF_IRQ_STATUS: next_rdata = {30'h0000_0000, ev_status};
            `ITC_OFF_IRQ_MASK:   next_rdata = {30'h0000_0000, ev_mask};
            default:             next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (req.psel && req.penable && !pready && !req.pwrite)
            prdata <= next_rdata;
    end
endmodule

// File: test/itc_checker.sv
// port-level assertion checker of the interrupt pacing block
`timescale 1ns/1ps
module itc_checker
    import itc_pkg::*;
#(
    parameter int UNIT_CYCLES = 7
)
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [16:0] hw_cause,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        host_irq,
    input wire logic        irq
);
    logic [15:0] ivl;
    int          gap;
    // shadow of the interval taken from completed writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ivl <= 16'h0000;
        else if (psel && penable && pready && pwrite && paddr == 12'h0C4)
            ivl <= pwdata[15:0];
    end
    // cycles since the last host interrupt rise
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gap <= 1000000;
        else if ($rose(host_irq))
            gap <= 1;
        else if (gap < 1000000)
            gap <= gap + 1;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    pready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
    one_wait_a: assert property ($rose(psel && penable) |-> !pready ##1 pready) else $error("wrong wait state");
    ready_xfer_a: assert property (pready |-> psel && penable) else $error("pready outside access");
    err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    unmapped_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read data");
    force_reads_a: assert property (pready && !pwrite && paddr == 12'h0C8 |-> prdata == 32'h0)
        else $error("force register read not zero");
    interval_read_a: assert property (pready && !pwrite && paddr == 12'h0C4 |-> prdata == {16'h0000, ivl})
        else $error("interval readback wrong");
    rdata_hold_a: assert property (!(pready && !pwrite) |-> $stable(prdata)) else $error("prdata moved");
    reset_quiet_a: assert property ($rose(presetn) |-> !pready && !host_irq && !irq) else $error("output after reset");
    pacing_gap_a: assert property ($rose(host_irq) && ivl != 16'h0000 |-> gap >= int'(ivl) * UNIT_CYCLES)
        else $error("host interrupts too close");
endmodule

bind itc_top itc_checker #(.UNIT_CYCLES(UNIT_CYCLES)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .hw_cause(hw_cause),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .host_irq(host_irq), .irq(irq));

// File: test/itc_host_model.sv
// host-side model that times the interrupts it receives
`timescale 1ns/1ps
module itc_host_model
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic host_irq,
    output int        gap,
    output int        rises
);
    int   cnt;
    logic seen;
    // measure cycles between two interrupt assertions
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 0;
            seen <= 1'b0;
            gap <= 0;
            rises <= 0;
        end
        else
        begin
            seen <= host_irq;
            cnt <= (host_irq && !seen) ? 1 : cnt + 1;
            if (host_irq && !seen)
            begin
                gap <= cnt;
                rises <= rises + 1;
            end
        end
    end
endmodule

// File: test/testbench.sv
// self-checking testbench of the interrupt pacing block
`timescale 1ns/1ps
module testbench
    import itc_pkg::*;
;
    localparam int U = 1;
    localparam int N = 651;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, host_irq, irq, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [16:0] hw_cause;
    int          errors, n_checks, gap, rises;

    itc_top #(.WIDE_GPI(1'b0), .UNIT_CYCLES(U)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .hw_cause(hw_cause),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .host_irq(host_irq), .irq(irq));
    itc_host_model HOST (.pclk(pclk), .presetn(presetn), .host_irq(host_irq), .gap(gap), .rises(rises));

    // free-running bus clock
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic print_verdict();
        if (errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one bus transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk({31'h0, pready}, 32'h1);
        if (pready !== 1'b1)
            print_verdict();
    endtask

    // bounded wait for the host interrupt level
    task automatic wait_irq(input logic v, input int lim);
        int k;
        k = 0;
        while (host_irq !== v && k < lim)
        begin
            @(posedge pclk);
            k++;
        end
        chk({31'h0, host_irq}, {31'h0, v});
        if (host_irq !== v)
            print_verdict();
        @(posedge pclk);
    endtask

    task automatic t_reset();
        apb(1'b0, 12'h0C4, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h0D0, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, er}, 32'h1);
    endtask

    task automatic t_force();
        for (int i = 0; i < 17; i++)
        begin
            if (i != 5 && i != 8 && i != 11)
            begin
                apb(1'b1, 12'h0C8, 32'h1 << i);
                apb(1'b0, 12'h0C0, 32'h0);
                chk(rd, 32'h1 << i);
            end
        end
        apb(1'b1, 12'h0C8, 32'h00000004);
        apb(1'b1, 12'h0C8, 32'h00010000);
        apb(1'b0, 12'h0C0, 32'h0);
        chk(rd, 32'h00010004);
        hw_cause <= 17'h00002;
        @(posedge pclk);
        hw_cause <= 17'h00000;
        apb(1'b0, 12'h0C0, 32'h0);
        chk(rd, 32'h00000002);
        // reserved force bits must not land in the cause register
        apb(1'b1, 12'h0C8, 32'hFFFF_FFFF);
        apb(1'b0, 12'h0C0, 32'h0);
        chk(rd, 32'h0001F6DF);
        // cause clear drops only the bits written as one
        apb(1'b1, 12'h0C8, 32'h00000003);
        apb(1'b1, 12'h0DC, 32'h00000001);
        apb(1'b0, 12'h0C0, 32'h0);
        chk(rd, 32'h00000002);
    endtask

    task automatic t_mask();
        apb(1'b1, 12'h0C8, 32'h00000004);
        repeat (6) @(posedge pclk);
        chk({31'h0, host_irq}, 32'h0);
        apb(1'b1, 12'h0D0, 32'h00000004);
        wait_irq(1'b1, 8);
        apb(1'b0, 12'h0C0, 32'h0);
        wait_irq(1'b0, 8);
        apb(1'b0, 12'h0E0, 32'h0);
        chk(rd, 32'h00000003);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 12'h0E4, 32'h00000001);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, 12'h0E0, 32'h00000001);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 12'h0E0, 32'h00000002);
    endtask

    task automatic t_pace();
        // start value from the suggested range, reserved bits zero
        apb(1'b1, 12'h0C4, N);
        apb(1'b0, 12'h0C4, 32'h0);
        chk(rd, N);
        repeat (N * U + 10) @(posedge pclk);
        apb(1'b1, 12'h0C8, 32'h00000004);
        wait_irq(1'b1, N * U + 20);
        apb(1'b0, 12'h0C0, 32'h0);
        wait_irq(1'b0, 8);
        apb(1'b1, 12'h0C8, 32'h00000004);
        repeat (20) @(posedge pclk);
        chk({31'h0, host_irq}, 32'h0);
        wait_irq(1'b1, N * U + 20);
        chk({31'h0, gap >= N * U}, 32'h1);
        chk({31'h0, gap <= N * U + 12}, 32'h1);
        apb(1'b0, 12'h0C0, 32'h0);
        wait_irq(1'b0, 8);
    endtask

    task automatic t_bypass();
        apb(1'b1, 12'h0C4, 32'h0);
        apb(1'b1, 12'h0C8, 32'h00000004);
        wait_irq(1'b1, 8);
        apb(1'b0, 12'h0C0, 32'h0);
        wait_irq(1'b0, 8);
        apb(1'b1, 12'h0C8, 32'h00000004);
        wait_irq(1'b1, 8);
        chk({31'h0, gap <= 30}, 32'h1);
        // clearing the mask withdraws the host interrupt
        apb(1'b1, 12'h0D8, 32'h00000004);
        wait_irq(1'b0, 8);
        apb(1'b0, 12'h0D0, 32'h0);
        chk(rd, 32'h0);
    endtask

    // reset, then every scenario in turn
    initial
    begin
        errors = 0;
        n_checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        hw_cause = 17'h00000;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_force();
        t_mask();
        t_pace();
        t_bypass();
        print_verdict();
    end
endmodule
